// ==== src/pzm_mgmt_master.sv ====
/*
 * Management master serialiser: divides pclk into the management clock and
 * shifts one word out on the data pin, most significant bit first.
 * Assumes the word is held stable by the caller only on the start pulse.
 */
`timescale 1ns/1ps
module pzm_mgmt_master #(
	parameter int HALF = pzm_pkg::MDC_HALF_CYC,
	parameter int WORD = pzm_pkg::MGMT_WORD
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            start,
	input  wire logic [WORD-1:0] word,
	output logic                 mdc,
	output logic                 mdio_drv,
	output logic                 mdio_oe,
	output logic                 busy
);

	logic [WORD-1:0]        shreg;  // Bits still to send
	logic [$clog2(WORD):0]  left;   // Bits remaining
	logic [$clog2(HALF+1):0] div;   // Half period counter
	logic                   half;   // Half period elapsed

	assign half = (div == ($bits(div))'(HALF - 1));

	// ************************************************************
	// Clock divider; runs only while busy so the line sits quiet
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= '0;
			mdc <= 1'b0;
		end else if (!busy || half) begin
			div <= '0;
			mdc <= busy ? ~mdc : 1'b0;
		end else begin
			div <= div + 1'b1;
		end
	end

	// ************************************************************
	// Shifter; data changes on the falling clock so the PHY
	// samples a settled bit on the rising one
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shreg    <= '0;
			left     <= '0;
			busy     <= 1'b0;
			mdio_drv <= 1'b1;
			mdio_oe  <= 1'b0;
		end else if (start && !busy) begin
			shreg    <= word << 1;
			left     <= ($bits(left))'(WORD);
			busy     <= 1'b1;
			mdio_drv <= word[WORD-1];
			mdio_oe  <= 1'b1;
		end else if (busy && half && mdc) begin
			if (left == ($bits(left))'(1)) begin
				busy     <= 1'b0;
				mdio_oe  <= 1'b0; // Release after last bit
				mdio_drv <= 1'b1;
				left     <= '0;
			end else begin
				left     <= left - 1'b1;
				mdio_drv <= shreg[WORD-1];
				shreg    <= shreg << 1;
			end
		end
	end

endmodule

// ==== src/pzm_pkg.sv ====
/*
 * Shared constants, types and register map for the port zero status and
 * management pin block. Assumes a 40 MHz APB clock.
 */
// Overview of operation
// - MAC mode: carrier pin is input
// - PHY mode: drive carrier pin toward MAC
// - Isolate bit disables carrier output driver
// - RMII PHY: carrier pin unused, undriven
// - MAC mode: duplex follows live pin
// - Autoneg enable overrides duplex pin; here in MAC mode only, PHY modes keep the pin
// - PHY modes: partner ability from duplex
// - Slave modes: data pin input only, never driven
// - Master mode: data pin bidirectional; here only driven, never read
// - Slave modes: clock pin input only
// - Master mode: device drives clock
// - Idle data line released, reads one
// - Straps latched at reset release
package pzm_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int PCLK_PERIOD_NS = 25;  // APB clock period
	localparam int MDC_PERIOD_NS  = 400; // Least management clock period
	// Half period rounded up so the clock is never faster than allowed
	localparam int MDC_HALF_CYC   =
		(MDC_PERIOD_NS / 2 + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] REG_CTRL   = 8'h00; // Control
	localparam logic [7:0] REG_STATUS = 8'h04; // Status
	localparam logic [7:0] REG_MGMT_TX = 8'h08; // Master shift word
	localparam logic [7:0] REG_MGMT_RX = 8'h0C; // Slave capture word

	// Control fields
	localparam int CTRL_ISO_BIT    = 0; // Isolate
	localparam int CTRL_AN_BIT     = 1; // Autoneg enable
	localparam int CTRL_NEGDUP_BIT = 2; // Negotiated duplex result
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Status fields
	localparam int STAT_MODE_LSB   = 0; // Strapped port mode, 2 bits
	localparam int STAT_MASTER_BIT = 2; // Strapped management master
	localparam int STAT_DUP_BIT    = 3; // Effective duplex
	localparam int STAT_ABIL_LSB   = 4; // Partner ability, 4 bits
	localparam int STAT_BUSY_BIT   = 8; // Master shift busy
	localparam int STAT_CRS_BIT    = 9; // Carrier seen

	// Ability encodings {100FD,100HD,10FD,10HD}
	localparam logic [3:0] ABIL_FULL = 4'hF;
	localparam logic [3:0] ABIL_HALF = 4'h5;

	// Mode strap encodings
	localparam logic [1:0] STRAP_MII_MAC  = 2'h0;
	localparam logic [1:0] STRAP_MII_PHY  = 2'h1;

	localparam int MGMT_WORD = 32; // Serial word length

	typedef enum logic [1:0] {
		PZM_MII_MAC,
		PZM_MII_PHY,
		PZM_RMII_PHY
	} pzm_mode_e;

	typedef struct packed {
		logic [1:0] mode;        // Port mode strap
		logic       mgmt_master; // Management master strap
		logic       dup_pol;     // Duplex polarity strap
	} pzm_strap_s;

	typedef struct packed {
		logic drv;  // Output level
		logic oe;   // Output enable
	} pzm_pin_s;

endpackage

// ==== src/pzm_port_pins.sv ====
/*
 * Port zero carrier sense, duplex and management pin logic with an APB
 * register slave. Assumes pins arrive asynchronous to pclk, that the
 * management clock pin is a separate clock domain in slave modes, and that
 * external pull-ups hold the data line high when nobody drives it.
 */
`timescale 1ns/1ps
module pzm_port_pins #(
	parameter int HALF = pzm_pkg::MDC_HALF_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Strap pins, sampled after reset release
	input  wire logic [1:0]  port_mode_strap,
	input  wire logic        mgmt_master_strap,
	input  wire logic        port_zero_duplex_polarity_strap,
	// Internal carrier indication from the switch core
	input  wire logic        carrier_present,
	// Carrier sense pin
	input  wire logic        port_zero_carrier_sense_i,
	output logic             port_zero_carrier_sense_o,
	output logic             port_zero_carrier_sense_oe,
	// Duplex pin
	input  wire logic        port_zero_duplex_input,
	// Management clock pin; input side is the link clock
	input  wire logic        mgmt_clock_in,
	output logic             mgmt_clock_o,
	output logic             mgmt_clock_oe,
	// Management data pin
	input  wire logic        mgmt_data_i,
	output logic             mgmt_data_o,
	output logic             mgmt_data_oe,
	// Derived status toward the core
	output logic             duplex_full,
	output logic [3:0]       partner_ability,
	output logic             link_carrier
);

	// ************************************************************
	// Declarations
	// ************************************************************
	pzm_pkg::pzm_strap_s strap;      // Latched straps
	logic                strap_done; // Straps captured once
	pzm_pkg::pzm_mode_e  mode;       // Decoded port mode
	logic [2:0]          ctrl;       // Control register
	logic [31:0]         tx_word;    // Word for master shifter
	logic                tx_start;   // One-cycle start pulse
	logic                eng_mdc;    // Engine clock
	logic                eng_drv;    // Engine data level
	logic                eng_oe;     // Engine data enable
	logic                eng_busy;   // Engine busy
	logic [1:0]          dup_sync;   // Duplex pin synchroniser
	logic [1:0]          crs_sync;   // Carrier pin synchroniser
	logic                dup_pin;    // Duplex after polarity
	logic                next_dup;   // Effective duplex
	logic [3:0]          next_abil;  // Ability bits
	logic                access;     // APB access phase
	logic [31:0]         next_rdata; // Read mux
	logic                next_err;   // Unmapped address
	logic                iso;        // Isolate bit
	logic                an_en;      // Autoneg enable
	// Link domain
	logic [31:0]         lk_shift;   // Captured serial bits
	logic [4:0]          lk_count;   // Bits in current word
	logic [31:0]         lk_hold;    // Completed word
	logic                lk_tog;     // Flips per completed word
	// Crossing into pclk
	logic [2:0]          tog_sync;   // Toggle synchroniser plus history
	logic [31:0]         rx_word;    // Last captured word

	assign iso   = ctrl[pzm_pkg::CTRL_ISO_BIT];
	assign an_en = ctrl[pzm_pkg::CTRL_AN_BIT];

	// ************************************************************
	// Strap capture
	// ************************************************************
	// Caught on the first edge after reset release; a reset value
	// may not come from a pin, so the flag gates a clocked load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap      <= '0;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			strap.mode        <= port_mode_strap;
			strap.mgmt_master <= mgmt_master_strap;
			strap.dup_pol     <= port_zero_duplex_polarity_strap;
			strap_done        <= 1'b1;
		end
	end

	// Mode decode from the latched strap
	always_comb begin
		case (strap.mode)
			pzm_pkg::STRAP_MII_MAC: mode = pzm_pkg::PZM_MII_MAC;
			pzm_pkg::STRAP_MII_PHY: mode = pzm_pkg::PZM_MII_PHY;
			default:                mode = pzm_pkg::PZM_RMII_PHY;
		endcase
	end

	// ************************************************************
	// Pin input synchronisers
	// ************************************************************
	// Two flops each; only the second stage is read below
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dup_sync <= '0;
			crs_sync <= '0;
		end else begin
			dup_sync <= {dup_sync[0], port_zero_duplex_input};
			crs_sync <= {crs_sync[0], port_zero_carrier_sense_i};
		end
	end

	// ************************************************************
	// Duplex and ability
	// ************************************************************
	// Polarity strap set means a low pin marks full duplex
	assign dup_pin = dup_sync[1] ^ strap.dup_pol;

	always_comb begin
		next_dup  = 1'b0;
		next_abil = pzm_pkg::ABIL_HALF;
		case (mode)
			pzm_pkg::PZM_MII_MAC: begin
				// Negotiated result wins over the pin
				if (an_en) begin
					next_dup = ctrl[pzm_pkg::CTRL_NEGDUP_BIT];
				end else begin
					next_dup = dup_pin;      // Live level
				end
				next_abil = pzm_pkg::ABIL_HALF;
			end
			pzm_pkg::PZM_MII_PHY,
			pzm_pkg::PZM_RMII_PHY: begin
				// Virtual partner abilities follow the pin
				next_abil = dup_pin ? pzm_pkg::ABIL_FULL
				                    : pzm_pkg::ABIL_HALF;
				next_dup  = dup_pin;
			end
			default: begin
				next_dup  = 1'b0;
				next_abil = pzm_pkg::ABIL_HALF;
			end
		endcase
	end

	// Re-evaluated every cycle so pin changes are never missed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duplex_full     <= 1'b0;
			partner_ability <= pzm_pkg::ABIL_HALF;
		end else begin
			duplex_full     <= next_dup;
			partner_ability <= next_abil;
		end
	end

	// ************************************************************
	// Carrier sense pin
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_zero_carrier_sense_o  <= 1'b0;
			port_zero_carrier_sense_oe <= 1'b0;
			link_carrier               <= 1'b0;
		end else begin
			case (mode)
				pzm_pkg::PZM_MII_MAC: begin
					// External PHY owns the pin
					port_zero_carrier_sense_oe <= 1'b0;
					port_zero_carrier_sense_o  <= 1'b0;
					link_carrier               <= crs_sync[1];
				end
				pzm_pkg::PZM_MII_PHY: begin
					// Drive the MAC unless isolated
					port_zero_carrier_sense_oe <= ~iso;
					port_zero_carrier_sense_o  <= carrier_present;
					link_carrier               <= carrier_present;
				end
				default: begin
					// Pin has no use here
					port_zero_carrier_sense_oe <= 1'b0;
					port_zero_carrier_sense_o  <= 1'b0;
					link_carrier               <= carrier_present;
				end
			endcase
		end
	end

	// ************************************************************
	// Master mode management engine
	// ************************************************************
	pzm_mgmt_master #(
		.HALF (HALF),
		.WORD (pzm_pkg::MGMT_WORD)
	) u_master (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (tx_start),
		.word     (tx_word),
		.mdc      (eng_mdc),
		.mdio_drv (eng_drv),
		.mdio_oe  (eng_oe),
		.busy     (eng_busy)
	);

	// Pin drivers; slave modes never drive clock or data here, so
	// the line stays released and pulled high while idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mgmt_clock_o  <= 1'b0;
			mgmt_clock_oe <= 1'b0;
			mgmt_data_o   <= 1'b1;
			mgmt_data_oe  <= 1'b0;
		end else if (strap.mgmt_master) begin
			mgmt_clock_o  <= eng_mdc;
			mgmt_clock_oe <= 1'b1;
			mgmt_data_o   <= eng_drv;
			mgmt_data_oe  <= eng_oe;
		end else begin
			mgmt_clock_o  <= 1'b0;
			mgmt_clock_oe <= 1'b0;
			mgmt_data_o   <= 1'b1;
			mgmt_data_oe  <= 1'b0;
		end
	end

	// ************************************************************
	// Link domain: slave mode capture on the external clock
	// ************************************************************
	// Bits are taken on the rising management clock; only whole
	// words leave this domain, announced by a toggle
	always_ff @(posedge mgmt_clock_in or negedge presetn) begin
		if (!presetn) begin
			lk_shift <= '0;
			lk_count <= '0;
			lk_hold  <= '0;
			lk_tog   <= 1'b0;
		end else begin
			lk_shift <= {lk_shift[30:0], mgmt_data_i};
			lk_count <= lk_count + 1'b1;
			if (lk_count == 5'(pzm_pkg::MGMT_WORD - 1)) begin
				lk_hold <= {lk_shift[30:0], mgmt_data_i};
				lk_tog  <= ~lk_tog;
			end
		end
	end

	// ************************************************************
	// Word crossing into pclk
	// ************************************************************
	// The held word is stable for a whole word time, far longer
	// than the synchroniser delay, so it is safe to sample on the
	// toggle edge. Limitation: words are only seen in slave mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_sync <= '0;
			rx_word  <= '0;
		end else begin
			tog_sync <= {tog_sync[1:0], lk_tog};
			if ((tog_sync[2] ^ tog_sync[1]) && !strap.mgmt_master) begin
				rx_word <= lk_hold;
			end
		end
	end

	// ************************************************************
	// APB slave
	// ************************************************************
	// One wait state: pready rises one cycle into the access phase
	assign access = psel && penable && !pready;

	// Read mux and address decode
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		case (paddr)
			pzm_pkg::REG_CTRL: begin
				next_rdata[2:0] = ctrl;
			end
			pzm_pkg::REG_STATUS: begin
				next_rdata[pzm_pkg::STAT_MODE_LSB +: 2] = strap.mode;
				next_rdata[pzm_pkg::STAT_MASTER_BIT] = strap.mgmt_master;
				next_rdata[pzm_pkg::STAT_DUP_BIT]    = duplex_full;
				next_rdata[pzm_pkg::STAT_ABIL_LSB +: 4] = partner_ability;
				next_rdata[pzm_pkg::STAT_BUSY_BIT]   = eng_busy;
				next_rdata[pzm_pkg::STAT_CRS_BIT]    = link_carrier;
			end
			pzm_pkg::REG_MGMT_TX: begin
				next_rdata = tx_word;
			end
			pzm_pkg::REG_MGMT_RX: begin
				next_rdata = rx_word;
			end
			default: begin
				next_err = 1'b1;
			end
		endcase
	end

	// Handshake and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= access;
			pslverr <= access && next_err;
			if (access && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	// Register writes land at the edge pready is sampled high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= pzm_pkg::CTRL_RESET;
			tx_word  <= 32'h0000_0000;
			tx_start <= 1'b0;
		end else begin
			tx_start <= 1'b0;
			if (psel && penable && pready && pwrite) begin
				if (paddr == pzm_pkg::REG_CTRL) begin
					ctrl <= pwdata[2:0];
				end
				// Start is refused while a word is still going out
				if (paddr == pzm_pkg::REG_MGMT_TX && !eng_busy) begin
					tx_word  <= pwdata;
					tx_start <= strap.mgmt_master;
				end
			end
		end
	end

endmodule

// ==== test/pzm_mgmt_peer.sv ====
/* Far-side management party: master in slave modes, PHY in master mode.
   Assumes the bench resolves the wires, with a pull-up on data. */
`timescale 1ns/1ps
module pzm_mgmt_peer (
	input wire logic line,    // Resolved data wire
	input wire logic mdc_in,  // Resolved clock wire
	output logic     clk_out, // Clock we supply as master
	output logic     d_out,   // Data we drive
	output logic     d_oe     // Our data driver enable
);
	logic [31:0] rx_word; // Last 32 bits seen on rising clock
	initial begin
		clk_out = 1'b0;
		d_out = 1'b1;
		d_oe = 1'b0;
		rx_word = 32'h0;
	end
	// Capture as a PHY would, on the rising clock edge
	always @(posedge mdc_in) begin
		rx_word <= {rx_word[30:0], line};
	end
	// Send one word at 64 ns; clock stands low outside the frame
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			d_oe = 1'b1;
			d_out = w[i];
			#32 clk_out = 1'b1;
			#32 clk_out = 1'b0;
		end
		d_oe = 1'b0;
		d_out = ~w[0];
	endtask
endmodule

// ==== test/pzm_port_pins_sva.sv ====
/* Checker for the port zero pin block; sees only top-level ports.
   Assumes straps are held steady outside reset. */
`timescale 1ns/1ps
module pzm_port_pins_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [1:0]  port_mode_strap,
	input wire logic        mgmt_master_strap,
	input wire logic        port_zero_duplex_polarity_strap,
	input wire logic        carrier_present,
	input wire logic        port_zero_carrier_sense_o,
	input wire logic        port_zero_carrier_sense_oe,
	input wire logic        port_zero_duplex_input,
	input wire logic        mgmt_clock_o,
	input wire logic        mgmt_clock_oe,
	input wire logic        mgmt_data_o,
	input wire logic        mgmt_data_oe,
	input wire logic        duplex_full,
	input wire logic [3:0]  partner_ability
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ************************************************************
	// Shadow of the control word
	// ************************************************************
	logic mac;     // Strap says MII MAC
	logic ctrl_wr; // Completed control write
	logic an_q;    // Autoneg enable as written
	logic nd_q;    // Negotiated duplex as written
	logic dpx;     // Duplex pin after polarity
	assign mac = port_mode_strap == pzm_pkg::STRAP_MII_MAC;
	assign ctrl_wr = psel && penable && pready && pwrite
		&& paddr == pzm_pkg::REG_CTRL;
	assign dpx = port_zero_duplex_input ^ port_zero_duplex_polarity_strap;
	// Track writes the same edge the slave takes them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			an_q <= 1'b0;
			nd_q <= 1'b0;
		end else if (ctrl_wr) begin
			an_q <= pwdata[pzm_pkg::CTRL_AN_BIT];
			nd_q <= pwdata[pzm_pkg::CTRL_NEGDUP_BIT];
		end
	end
	sequence s_ctrl_wr;
		ctrl_wr;
	endsequence
	// Six quiet cycles cover strap latch, sync and register stages
	sequence s_pin_quiet;
		(mac && !an_q && $stable({an_q, port_zero_duplex_input}))[*6];
	endsequence
	// ************************************************************
	// Properties
	// ************************************************************
	property p_mac_in;
		mac |-> !port_zero_carrier_sense_oe;
	endproperty
	property p_crs_drv;
		port_zero_carrier_sense_oe |->
			port_zero_carrier_sense_o == $past(carrier_present);
	endproperty
	property p_iso;
		s_ctrl_wr ##0 pwdata[pzm_pkg::CTRL_ISO_BIT]
			|=> ##1 !port_zero_carrier_sense_oe;
	endproperty
	property p_rmii;
		port_mode_strap[1] |->
			!port_zero_carrier_sense_oe && !port_zero_carrier_sense_o;
	endproperty
	property p_dup_live;
		s_pin_quiet |-> duplex_full == dpx;
	endproperty
	property p_dup_an;
		(mac && an_q && $stable({an_q, nd_q}))[*6] |-> duplex_full == nd_q;
	endproperty
	property p_abil;
		(!mac && $stable(port_zero_duplex_input))[*6] |-> partner_ability
			== (dpx ? pzm_pkg::ABIL_FULL : pzm_pkg::ABIL_HALF);
	endproperty
	property p_slave;
		!mgmt_master_strap |-> !mgmt_clock_oe && !mgmt_data_oe;
	endproperty
	property p_data_hold;
		mgmt_clock_o && $past(mgmt_clock_o) |-> $stable(mgmt_data_o);
	endproperty
	property p_mdc;
		$rose(mgmt_clock_o) |-> mgmt_clock_oe ##1 $stable(mgmt_clock_o);
	endproperty
	property p_idle;
		!mgmt_data_oe |-> mgmt_data_o;
	endproperty
	a_mac_in: assert property (p_mac_in)
		else $error("carrier pin driven in MAC mode");
	a_crs_drv: assert property (p_crs_drv)
		else $error("carrier output wrong");
	a_iso: assert property (p_iso)
		else $error("isolate left carrier driver on");
	a_rmii: assert property (p_rmii)
		else $error("carrier pin used in RMII mode");
	a_dup_live: assert property (p_dup_live)
		else $error("duplex not following pin");
	a_dup_an: assert property (p_dup_an)
		else $error("duplex not from negotiation");
	a_abil: assert property (p_abil)
		else $error("partner ability wrong");
	a_slave: assert property (p_slave)
		else $error("management pin driven in slave mode");
	a_data_hold: assert property (p_data_hold)
		else $error("data moved while clock high");
	a_mdc: assert property (p_mdc)
		else $error("management clock not driven");
	a_idle: assert property (p_idle)
		else $error("released data not high");
endmodule

bind pzm_port_pins pzm_port_pins_sva u_sva (.*);

// ==== test/pzm_port_pins_tb.sv ====
/* Self-checking bench for the port zero pin block.
   Assumes the peer model and checker are compiled alongside. */
`timescale 1ns/1ps
module pzm_port_pins_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [1:0]  mode;
	logic        mst, pol, cp, crs_drv, crs_o, crs_oe, dup, er, lc, dfull;
	logic        mco, mcoe, mdo, mdoe, p_clk, p_d, p_oe, line, mdc_w, crs_w;
	logic [3:0]  abil;
	int          error_cnt, n_checks;
	logic [31:0] exp_q[$]; // Words expected at the far end
	// Wires with pull-up on data; clock falls back to the peer's clock output
	assign line = mdoe ? mdo : (p_oe ? p_d : 1'b1);
	assign mdc_w = mcoe ? mco : p_clk;
	assign crs_w = crs_oe ? crs_o : crs_drv;
	pzm_port_pins #(.HALF(2)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .port_mode_strap(mode),
		.mgmt_master_strap(mst), .port_zero_duplex_polarity_strap(pol),
		.carrier_present(cp), .port_zero_carrier_sense_i(crs_w),
		.port_zero_carrier_sense_o(crs_o),
		.port_zero_carrier_sense_oe(crs_oe), .port_zero_duplex_input(dup),
		.mgmt_clock_in(mdc_w), .mgmt_clock_o(mco), .mgmt_clock_oe(mcoe),
		.mgmt_data_i(line), .mgmt_data_o(mdo), .mgmt_data_oe(mdoe),
		.duplex_full(dfull), .partner_ability(abil), .link_carrier(lc));
	pzm_mgmt_peer peer (.line(line), .mdc_in(mdc_w), .clk_out(p_clk),
		.d_out(p_d), .d_oe(p_oe));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// ************************************************************
	// Tasks
	// ************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Behavioural ability model
	function automatic logic [3:0] exp_abil(input logic d);
		return (d ^ pol) ? pzm_pkg::ABIL_FULL : pzm_pkg::ABIL_HALF;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 40);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 40) begin
			error_cnt++;
			$display("mismatch %0t bus hang", $time);
			final_report();
		end
	endtask
	// Straps must be steady across the release edge
	task automatic do_reset(input logic [1:0] m, input logic s,
		input logic p);
		@(posedge pclk);
		presetn <= 1'b0;
		mode <= m;
		mst <= s;
		pol <= p;
		cyc(16);
		presetn <= 1'b1;
		cyc(6);
		apb(1'b0, pzm_pkg::REG_STATUS, 32'h0);
		chk(32'(rd[2:0]), 32'({s, m}));
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{mode, mst, pol, cp, crs_drv, dup} = '0;
		error_cnt = 0;
		n_checks = 0;
		seed = 32'h0C92;
		// MII PHY, slave management
		do_reset(2'h1, 1'b0, 1'b0);
		for (int v = 0; v < 2; v++) begin
			cp <= v[0];
			cyc(3);
			chk(32'({crs_oe, crs_o}), 32'({1'b1, v[0]}));
		end
		apb(1'b1, pzm_pkg::REG_CTRL, 32'h1);
		cyc(2);
		chk(32'(crs_oe), 32'h0);
		apb(1'b1, pzm_pkg::REG_CTRL, 32'h0);
		for (int v = 0; v < 2; v++) begin
			dup <= v[0];
			cyc(6);
			chk(32'(abil), 32'(exp_abil(v[0])));
		end
		seed = lfsr(seed);
		peer.send(seed);
		cyc(8);
		apb(1'b0, pzm_pkg::REG_MGMT_RX, 32'h0);
		chk(rd, seed);
		chk(32'({mcoe, mdoe}), 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(er), 32'h1); // Unmapped read refused
		chk(rd, 32'h0); // Unmapped read returns zero
		// MII MAC, master management, inverted duplex
		do_reset(2'h0, 1'b1, 1'b1);
		for (int v = 0; v < 4; v++) begin
			seed = lfsr(seed);
			crs_drv <= seed[0];
			dup <= seed[1];
			cyc(5);
			chk(32'({crs_oe, lc}), 32'({1'b0, seed[0]}));
			chk(32'(dfull), 32'(!seed[1]));
		end
		apb(1'b1, pzm_pkg::REG_CTRL, 32'h6);
		for (int v = 0; v < 2; v++) begin
			dup <= v[0];
			cyc(5);
			chk(32'(dfull), 32'h1);
		end
		apb(1'b1, pzm_pkg::REG_CTRL, 32'h2);
		cyc(3);
		chk(32'(dfull), 32'h0);
		apb(1'b1, pzm_pkg::REG_CTRL, 32'h0);
		seed = lfsr(seed);
		exp_q.push_back(seed);
		apb(1'b1, pzm_pkg::REG_MGMT_TX, seed);
		for (int k = 0; k <= 100; k++) begin
			apb(1'b0, pzm_pkg::REG_STATUS, 32'h0);
			if (rd[pzm_pkg::STAT_BUSY_BIT] === 1'b0) begin
				break;
			end
			if (k == 100) begin
				error_cnt++;
				$display("mismatch %0t master busy stuck", $time);
				final_report();
			end
		end
		chk(peer.rx_word, exp_q.pop_front());
		chk(32'(line), 32'h1);
		// RMII PHY: carrier pin left alone
		do_reset(2'h2, 1'b0, 1'b0);
		cp <= 1'b1;
		cyc(4);
		chk(32'({crs_oe, crs_o}), 32'h0);
		final_report();
	end
endmodule
